/* logic/video_addr_defs.svh */
/*
  Constants for the display file address generator: region bases, strides,
  the mode port and the mode field values.
  Assumes it is included by bare name into the mode latch and address generator files.
*/
`ifndef VIDEO_ADDR_DEFS_SVH
`define VIDEO_ADDR_DEFS_SVH

`define PRIMARY_BASE   16'h4000
`define SECOND_BASE    16'h6000
`define FILE_SIZE      16'h1B00
`define FILE_SEL_BIT   13
`define ROW_STRIDE     16'h0100
`define LINE_STRIDE    16'h0020
`define BLOCK0_BASE    16'h4000
`define BLOCK1_BASE    16'h4800
`define BLOCK2_BASE    16'h5000
`define ATTR_BASE      16'h5800
`define ATTR_COUNT     16'h0300
`define SCREEN_LINES   5'h18
`define NARROW_COLS    6'h20
`define MODE_PORT      8'hFF
`define MODE_LSB       0
`define MODE_MSB       5
`define MODE_NORMAL    6'h00
`define MODE_DUAL      6'h01
`define MODE_HICOLOR   6'h02
`define MODE_WIDE64    6'h06
`define MODE_RESET     6'h00

`endif

/* logic/video_addr_pkg.sv */
/*
  Types shared by the display file address generator and its mode latch.
  Assumes video_addr_defs.svh is on the include path.
*/
package video_addr_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } io_write_t;

  typedef struct packed {
    logic [4:0] line;
    logic [2:0] row;
    logic [5:0] col;
  } cell_pos_t;

  typedef struct packed {
    logic [15:0] pix_addr;
    logic [15:0] attr_addr;
    logic        attr_en;
  } fetch_t;

endpackage

/* logic/video_mode_latch.sv */
/*
  Holds the video mode field written by the host to the mode port.
  Assumes the host write strobe is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/100ps
`include "video_addr_defs.svh"

module video_mode_latch (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    io_wr,
  input  wire video_addr_pkg::io_write_t io_port,
  output logic [5:0]                   video_mode
);

  logic [5:0] mode_r;
  logic [5:0] mode_nxt;
  wire        port_hit;

  assign port_hit   = io_wr && (io_port.addr == `MODE_PORT);
  assign mode_nxt   = port_hit ? io_port.data[`MODE_MSB:`MODE_LSB] : mode_r;
  assign video_mode = mode_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= `MODE_RESET;
    end else begin
      mode_r <= mode_nxt; // RULE3
    end
  end

  mode_write_a: assert property ( // RULE3
    @(posedge sys_clk) disable iff (rst)
    port_hit |=> (video_mode == $past(io_port.data[5:0])))
    else $error("Mode field did not take the written value.");

  mode_hold_a: assert property ( // RULE3
    @(posedge sys_clk) disable iff (rst)
    !port_hit |=> $stable(video_mode))
    else $error("Mode field changed without a port write.");

endmodule

/* logic/video_addr_gen.sv */
/*
  Display file address generator: turns a character position and scan row
  into the pixel and attribute fetch addresses for the selected video mode.
  Assumes the raster logic presents one position per request on sys_clk and
  that the host writes the mode port on the same clock.
*/
//
// Contract
// RULE1: Fetch from primary 4000H and second 6000H.
// RULE2: Each display file spans 1B00H bytes.
// RULE3: Mode is bits 0-5 of port FFH.
// RULE4: Pixel area is three blocks of eight lines.
// RULE5: The two files differ only in bit 13.
// RULE6: Eight scan rows per cell, 100H apart.
// RULE7: Normal attributes at 5800H, 768 bytes, row order.
// RULE8: Lines step 20H; blocks at 4000H, 4800H, 5000H.
// RULE9: In 64-column mode odd columns use second file.
// RULE10: Mode 1 shows the second display file.
// RULE11: Mode 2 takes attribute from second file offset.
// RULE12: Mode 0 shows primary pixels, normal attributes.
`timescale 1ns/100ps
`include "video_addr_defs.svh"

module video_addr_gen (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      io_wr,
  input  wire video_addr_pkg::io_write_t io_port,
  input  wire logic                      req_valid,
  input  wire video_addr_pkg::cell_pos_t req_pos,
  output logic                           req_ready,
  output logic                           out_valid,
  output video_addr_pkg::fetch_t         out_fetch,
  output logic [5:0]                     video_mode
);

  // Pixel byte address inside one display file for a line, scan row and column.
  function automatic logic [15:0] pix_addr_f(
    input logic [4:0] line,
    input logic [2:0] row,
    input logic [4:0] col,
    input logic       second
  );
    logic [15:0] blk;
    logic [15:0] a;
    blk = (line[4:3] == 2'h0) ? `BLOCK0_BASE :
          (line[4:3] == 2'h1) ? `BLOCK1_BASE : `BLOCK2_BASE; // RULE4 RULE8
    a = blk | {5'h00, row, 8'h00} | {8'h00, line[2:0], 5'h00} | {11'h000, col}; // RULE6 RULE8
    a[`FILE_SEL_BIT] = second; // RULE5
    return a;
  endfunction

  // Attribute byte address in the normal attribute file.
  function automatic logic [15:0] attr_addr_f(
    input logic [4:0] line,
    input logic [4:0] col
  );
    return `ATTR_BASE + {6'h00, line, col}; // RULE7
  endfunction

  logic [5:0]              mode;
  logic                    out_valid_r;
  logic                    out_valid_nxt;
  video_addr_pkg::fetch_t  fetch_r;
  video_addr_pkg::fetch_t  fetch_nxt;

  video_mode_latch mode_latch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .io_wr      (io_wr),
    .io_port    (io_port),
    .video_mode (mode)
  );

  wire        is_dual    = (mode == `MODE_DUAL);
  wire        is_hicolor = (mode == `MODE_HICOLOR);
  wire        is_wide    = (mode == `MODE_WIDE64);
  wire        line_ok    = req_pos.line < `SCREEN_LINES; // RULE2 RULE4
  wire        col_ok     = is_wide || (req_pos.col < `NARROW_COLS); // RULE2
  wire        accept     = req_valid && line_ok && col_ok;
  // In 64-column mode each file holds 32 columns; bit 0 picks the file.
  wire [4:0]  file_col   = is_wide ? req_pos.col[5:1] : req_pos.col[4:0]; // RULE9
  wire        second_sel = is_dual || (is_wide && req_pos.col[0]); // RULE9 RULE10
  wire [15:0] pix_a      = pix_addr_f(req_pos.line, req_pos.row, file_col, second_sel); // RULE1
  wire [15:0] norm_attr  = attr_addr_f(req_pos.line, req_pos.col[4:0]); // RULE12
  // Extended colour reads the attribute at the pixel's offset in the second file.
  wire [15:0] hic_attr   = pix_a | (16'h0001 << `FILE_SEL_BIT); // RULE11
  // Dual screen reuses the normal attribute layout, moved into the second file.
  wire [15:0] dual_attr  = norm_attr | (16'h0001 << `FILE_SEL_BIT); // RULE10

  // Any mode value this block does not know falls back to normal display, so
  // stray bits from the host never leave the screen dark.
  assign fetch_nxt.pix_addr  = pix_a;
  assign fetch_nxt.attr_addr = is_hicolor ? hic_attr : (is_dual ? dual_attr : norm_attr);
  assign fetch_nxt.attr_en   = !is_wide; // RULE9
  assign out_valid_nxt       = accept;

  // The generator never stalls; positions off the screen are simply dropped.
  assign req_ready  = 1'h1;
  assign out_valid  = out_valid_r;
  assign out_fetch  = fetch_r;
  assign video_mode = mode;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid_r <= 1'h0;
    end else begin
      out_valid_r <= out_valid_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_r <= '0;
    end else if (accept) begin
      fetch_r <= fetch_nxt;
    end
  end

  normal_file_a: assert property ( // RULE12
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_NORMAL
      |-> out_fetch.pix_addr[15:13] == 3'h2
          && out_fetch.attr_addr == `ATTR_BASE + {6'h00, $past(req_pos.line),
                                                  $past(req_pos.col[4:0])})
    else $error("Normal mode fetch left the primary file layout.");

  file_bases_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (rst)
    out_valid |-> out_fetch.pix_addr[15:14] == 2'h1)
    else $error("Pixel fetch outside both display files.");

  file_span_a: assert property ( // RULE2
    @(posedge sys_clk) disable iff (rst)
    out_valid |-> {3'h0, out_fetch.pix_addr[12:0]} < `FILE_SIZE
                  && (!out_fetch.attr_en || {3'h0, out_fetch.attr_addr[12:0]} < `FILE_SIZE))
    else $error("Fetch beyond the display file span.");

  block_pick_a: assert property ( // RULE4
    @(posedge sys_clk) disable iff (rst)
    out_valid |-> out_fetch.pix_addr[12:11] == $past(req_pos.line[4:3]))
    else $error("Wrong pixel block for the line.");

  row_step_a: assert property ( // RULE6
    @(posedge sys_clk) disable iff (rst)
    out_valid |-> out_fetch.pix_addr[10:8] == $past(req_pos.row))
    else $error("Scan row not placed at 100H steps.");

  line_step_a: assert property ( // RULE8
    @(posedge sys_clk) disable iff (rst)
    out_valid |-> out_fetch.pix_addr[7:5] == $past(req_pos.line[2:0]))
    else $error("Line not placed at 20H steps.");

  attr_range_a: assert property ( // RULE7
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_NORMAL
      |-> out_fetch.attr_addr - `ATTR_BASE < `ATTR_COUNT)
    else $error("Attribute fetch outside the attribute file.");

  pair_bit_a: assert property ( // RULE5
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_HICOLOR
      |-> out_fetch.attr_addr == (out_fetch.pix_addr | 16'h2000)
          && !out_fetch.pix_addr[13])
    else $error("Colour pair not separated by bit 13 alone.");

  wide_col_a: assert property ( // RULE9
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_WIDE64
      |-> out_fetch.pix_addr[13] == $past(req_pos.col[0])
          && out_fetch.pix_addr[4:0] == $past(req_pos.col[5:1]) && !out_fetch.attr_en)
    else $error("Wide mode column not split across the files.");

  dual_file_a: assert property ( // RULE10
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_DUAL
      |-> out_fetch.pix_addr[13] && out_fetch.attr_addr[15:8] == 8'h78
          || out_fetch.pix_addr[13] && out_fetch.attr_addr[15:8] inside {8'h79, 8'h7A})
    else $error("Dual screen fetch not from the second file.");

  drop_line_a: assert property ( // RULE4
    @(posedge sys_clk) disable iff (rst)
    req_valid && req_pos.line >= `SCREEN_LINES |=> !out_valid)
    else $error("Off-screen line produced a fetch.");

  drop_col_a: assert property ( // RULE2
    @(posedge sys_clk) disable iff (rst)
    req_valid && !is_wide && req_pos.col >= `NARROW_COLS |=> !out_valid)
    else $error("Off-screen column produced a fetch.");

  answer_next_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (rst)
    req_valid && req_pos.line < `SCREEN_LINES && req_pos.col < `NARROW_COLS |=> out_valid)
    else $error("On-screen position produced no fetch.");

  // Holding the last fetch lets a slow consumer reread it without a new request.
  fetch_hold_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (rst)
    !req_valid |=> $stable(out_fetch))
    else $error("Fetch address moved without a request.");

  hic_primary_a: assert property ( // RULE11
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_HICOLOR
      |-> out_fetch.attr_en && out_fetch.pix_addr[15:13] == 3'h2
          && out_fetch.attr_addr[15:13] == 3'h3)
    else $error("Extended colour pixel or attribute in the wrong file.");

  dual_attr_a: assert property ( // RULE10
    @(posedge sys_clk) disable iff (rst)
    out_valid && $past(mode) == `MODE_DUAL
      |-> out_fetch.attr_addr == (`ATTR_BASE | (16'h0001 << `FILE_SEL_BIT))
                                 + {6'h00, $past(req_pos.line), $past(req_pos.col[4:0])})
    else $error("Dual screen attribute not in the moved attribute file.");

  other_mode_a: assert property ( // RULE12
    @(posedge sys_clk) disable iff (rst)
    out_valid && !($past(mode) inside {`MODE_DUAL, `MODE_HICOLOR, `MODE_WIDE64})
      |-> out_fetch.attr_en && !out_fetch.pix_addr[13] && out_fetch.attr_addr[15:13] == 3'h2)
    else $error("Unknown mode did not fall back to normal display.");

endmodule

/* tb/host_model.sv */
/*
  Host side of the mode port: issues one-cycle writes on request of the bench.
  Assumes the bench calls write_port only while no fetch request is pending.
*/
`timescale 1ns/100ps

module host_model (
  input  wire logic                  sys_clk,
  output logic                       io_wr,
  output video_addr_pkg::io_write_t  io_port
);
  initial begin
    io_wr   = 1'b0;
    io_port = 16'h0000;
  end

  // After the strobe the port lines show the inverse, so a design that samples late fails.
  task automatic write_port(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_wr   <= 1'b1;
    io_port <= {a, d};
    @(posedge sys_clk);
    io_wr   <= 1'b0;
    io_port <= ~{a, d};
  endtask
endmodule

/* tb/video_display_file_addressing_bench.sv */
/*
  Self-checking bench for the display file address generator.
  Assumes host_model drives the mode port and the design answers one cycle after a request.
*/
`timescale 1ns/100ps

module video_display_file_addressing_bench;
  logic                       sys_clk;
  logic                       rst;
  logic                       io_wr;
  video_addr_pkg::io_write_t  io_port;
  logic                       req_valid;
  video_addr_pkg::cell_pos_t  req_pos;
  logic                       req_ready;
  logic                       out_valid;
  video_addr_pkg::fetch_t     out_fetch;
  logic [5:0]                 video_mode;
  logic [5:0]                 mode;
  logic                       pend_v;
  video_addr_pkg::fetch_t     pend_f;
  int                         n_fail;
  int                         comparisons;

  video_addr_gen dut (.sys_clk(sys_clk), .rst(rst), .io_wr(io_wr), .io_port(io_port),
    .req_valid(req_valid), .req_pos(req_pos), .req_ready(req_ready),
    .out_valid(out_valid), .out_fetch(out_fetch), .video_mode(video_mode));
  host_model host (.sys_clk(sys_clk), .io_wr(io_wr), .io_port(io_port));

  function automatic video_addr_pkg::fetch_t exp_fetch(video_addr_pkg::cell_pos_t p,
                                                       logic [5:0] m);
    video_addr_pkg::fetch_t f;
    logic [4:0]             c;
    c = (m == 6'h06) ? p.col[5:1] : p.col[4:0];
    f.pix_addr  = 16'h4000 + {p.line[4:3], 11'h000} + {p.row, 8'h00} + {p.line[2:0], 5'h00} + c;
    f.attr_addr = 16'h5800 + {p.line, 5'h00} + p.col[4:0];
    f.attr_en   = (m != 6'h06);
    if (m == 6'h01) f.pix_addr[13] = 1'b1;
    if (m == 6'h01) f.attr_addr[13] = 1'b1;
    if (m == 6'h02) f.attr_addr = f.pix_addr | 16'h2000;
    if (m == 6'h06) f.pix_addr[13] = p.col[0];
    return f;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Requests are pipelined: each call checks the answer to the previous one.
  task automatic step(input logic v, input video_addr_pkg::cell_pos_t p);
    @(posedge sys_clk);
    req_valid <= v;
    req_pos   <= p;
    #1;
    check({32'h0, out_valid}, {32'h0, pend_v});
    if (pend_v) check({out_fetch.pix_addr, 16'h0, out_fetch.attr_en},
      {pend_f.pix_addr, 16'h0, pend_f.attr_en});
    if (pend_v && pend_f.attr_en) check({17'h0, out_fetch.attr_addr},
      {17'h0, pend_f.attr_addr});
    pend_v = v && p.line < 5'h18 && (p.col < 6'h20 || mode == 6'h06);
    pend_f = exp_fetch(p, mode);
  endtask

  task automatic set_mode(input logic [7:0] a, input logic [7:0] d);
    step(1'b0, req_pos);
    host.write_port(a, d);
    if (a == 8'hFF) mode = d[5:0];
    #1;
    check({27'h0, video_mode}, {27'h0, mode});
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  initial begin
    logic [7:0] modes [6];
    modes       = '{8'h00, 8'h01, 8'hC2, 8'h06, 8'h03, 8'h2A};
    rst         = 1'b1;
    req_valid   = 1'b0;
    req_pos     = 14'h0000;
    mode        = 6'h00;
    pend_v      = 1'b0;
    pend_f      = 33'h0;
    n_fail      = 0;
    comparisons = 0;
    void'($urandom(26));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check(out_fetch, 33'h0);
    check({25'h0, out_valid, req_ready, video_mode}, {25'h0, 1'b0, 1'b1, 6'h00});
    set_mode(8'hFE, 8'h01);
    for (int i = 0; i < 6; i++) begin
      set_mode(8'hFF, modes[i]);
      step(1'b1, {5'h00, 3'h0, 6'h00});
      step(1'b1, {5'h17, 3'h7, 6'h1F});
      step(1'b1, {5'h11, 3'h0, 6'h17});
      step(1'b1, {5'h18, 3'h0, 6'h00});
      step(1'b1, {5'h08, 3'h3, 6'h3F});
      repeat (40) step($urandom % 4 != 0, {5'($urandom % 26), 3'($urandom), 6'($urandom)});
      $display("mode %h test done", modes[i]);
    end
    step(1'b0, req_pos);
    finish_test();
  end
endmodule
